// ==== core/bs_seq.sv ====
// Brown-out enable control and power-up start-up sequencer with APB registers.
//
// Contract
// - Sleep-gated config runs brown-out detection when awake, disables it in sleep.
// - Sleep-gated config re-enables brown-out detection on leaving sleep.
// - Enabled brown-out detection always requests the fixed voltage reference.
// - Brown-out detection acts only after reference settles; settled flag readable.
// - Disabled before reference settles means no brown-out reset from that period.
// - Config off keeps detection off; software enable bit unavailable.
// - Software config makes detection follow the software enable bit.
// - Config always-on keeps detection on; software enable bit unavailable.
// - Power-up timer counts 2048 low-frequency oscillator periods holding reset.
// - Power-up timer runs when its active-low disable bit is cleared.
// - Oscillator start-up counts 1024 primary oscillator cycles after power-up timer.
// - Oscillator start-up only in crystal modes, after power-on or oscillator restart; the code also runs it after a brown-out reset.
// - PLL mode adds a 2 ms lock time-out after oscillator start-up.
// - Power-up timer starts when power-on pulse ends, then oscillator start-up.
// - Resistor-capacitor mode without power-up timer releases reset directly.
// - Time-outs ignore master clear; release of the pin then starts execution.
// - Brown-out restarts power-up timer after recovery; new brown-out reinitialises it.
// - Software enable bit works only in software config, else reads zero.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "bs_regs.svh"
module bs_seq import bs_pkg::*; #(
	parameter int PLL_LOCK_CYCLES = (`BS_PLL_LOCK_PS + `BS_CLK_PERIOD_PS - 1) / `BS_CLK_PERIOD_PS
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`BS_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic power_on_pulse,
	input wire logic brownout_comparator,
	input wire logic master_clear_pin_n,
	input wire logic low_freq_internal_osc,
	input wire logic primary_osc_input,
	input wire logic reference_settled,
	input wire logic [1:0] brownout_enable_config,
	input wire logic power_up_timer_disable_n,
	input wire logic [2:0] osc_mode,
	input wire logic sleep_mode,
	input wire logic osc_restart,
	output logic brownout_active,
	output logic fixed_voltage_reference_request,
	output logic brownout_reset,
	output logic osc_ready,
	output logic core_reset_n
);

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		BS_REG_CTRL = 2'b00,
		BS_REG_STATUS = 2'b01,
		BS_REG_NONE = 2'b10
	} bs_reg_sel_t;

	function automatic bs_reg_sel_t reg_select(input logic [`BS_ADDR_W-1:0] addr);
		case (addr)
			`BS_OFF_CTRL: reg_select = BS_REG_CTRL;
			`BS_OFF_STATUS: reg_select = BS_REG_STATUS;
			default: reg_select = BS_REG_NONE;
		endcase
	endfunction

	function automatic logic crystal_mode(input logic [2:0] mode);
		case (mode)
			BS_OSC_LOW_POWER_CRYSTAL, BS_OSC_CRYSTAL, BS_OSC_HIGH_SPEED_CRYSTAL,
			BS_OSC_HIGH_SPEED_PLL: crystal_mode = 1'b1;
			default: crystal_mode = 1'b0;
		endcase
	endfunction

	// ------------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------------
	logic [`BS_NUM_ASYNC-1:0] async_pins;
	logic [`BS_NUM_ASYNC-1:0] pin_level;
	logic [`BS_NUM_ASYNC-1:0] pin_rise;

	assign async_pins = {reference_settled, primary_osc_input, low_freq_internal_osc,
		master_clear_pin_n, brownout_comparator, power_on_pulse};

	genvar gi;
	generate
		for (gi = 0; gi < `BS_NUM_ASYNC; gi = gi + 1) begin : g_sync
			bs_sync u_sync (
				.sys_clk(sys_clk),
				.resetn(resetn),
				.async_in(async_pins[gi]),
				.level(pin_level[gi]),
				.rise(pin_rise[gi])
			);
		end
	endgenerate

	logic por_level;
	logic bor_cmp_level;
	logic master_clear_pin_n_level;
	logic settled_level;

	assign por_level = pin_level[`BS_IN_POR];
	assign bor_cmp_level = pin_level[`BS_IN_BOR_CMP];
	assign master_clear_pin_n_level = pin_level[`BS_IN_MASTER_CLEAR_PIN_N_N];
	assign settled_level = pin_level[`BS_IN_SETTLED];

	// ------------------------------------------------------------------------
	// Brown-out enable control
	// ------------------------------------------------------------------------
	logic software_brownout_enable;
	logic next_brownout_active;
	logic bor_flag;
	logic ctrl_write;
	logic status_write;

	assign ctrl_write = psel && penable && pwrite && (reg_select(paddr) == BS_REG_CTRL);
	assign status_write = psel && penable && pwrite && (reg_select(paddr) == BS_REG_STATUS);

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			software_brownout_enable <= (brownout_enable_config == BS_BOR_SOFTWARE);
		end else if (brownout_enable_config != BS_BOR_SOFTWARE) begin
			software_brownout_enable <= 1'b0;
		end else if (ctrl_write) begin
			software_brownout_enable <= pwdata[`BS_CTRL_SWEN_BIT];
		end
	end

	always_comb begin
		case (brownout_enable_config)
			BS_BOR_OFF: next_brownout_active = 1'b0;
			BS_BOR_SOFTWARE: next_brownout_active = software_brownout_enable;
			BS_BOR_SLEEP_GATED: next_brownout_active = !sleep_mode;
			BS_BOR_ALWAYS_ON: next_brownout_active = 1'b1;
			default: next_brownout_active = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			brownout_active <= 1'b0;
		end else begin
			brownout_active <= next_brownout_active;
		end
	end

	assign fixed_voltage_reference_request = brownout_active;

	// A trip needs an enable that is still standing when the reference settles,
	// so an enable period cut short before settling never resets the core.
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			brownout_reset <= 1'b0;
		end else begin
			brownout_reset <= brownout_active && settled_level && bor_cmp_level;
		end
	end

	// Sticky brown-out status; a new trip wins over a clearing write.
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			bor_flag <= 1'b0;
		end else if (brownout_reset) begin
			bor_flag <= 1'b1;
		end else if (status_write && pwdata[`BS_STAT_BOR_FLAG_BIT]) begin
			bor_flag <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Start-up timers
	// ------------------------------------------------------------------------
	bs_state_t state;
	bs_state_t next_state;
	logic power_up_timer_done;
	logic ost_done;
	logic pll_done;
	logic in_reset_chain;
	logic power_up_timer_enabled;
	logic use_ost;
	logic use_pll;

	assign power_up_timer_enabled = !power_up_timer_disable_n;
	assign use_ost = crystal_mode(osc_mode);
	assign use_pll = (osc_mode == BS_OSC_HIGH_SPEED_PLL);

	bs_tick_counter #(.WIDTH(`BS_POWER_UP_TIMER_W)) u_power_up_timer (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.run(state == BS_ST_POWER_UP_TIMER),
		.tick(pin_rise[`BS_IN_LFOSC]),
		.target(`BS_POWER_UP_TIMER_TICKS),
		.done(power_up_timer_done)
	);

	bs_tick_counter #(.WIDTH(`BS_OST_W)) u_ost (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.run(state == BS_ST_OST),
		.tick(pin_rise[`BS_IN_POSC]),
		.target(`BS_OST_TICKS),
		.done(ost_done)
	);

	bs_tick_counter #(.WIDTH(`BS_PLL_CNT_W)) u_pll (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.run(state == BS_ST_PLL),
		.tick(1'b1),
		.target(`BS_PLL_CNT_W'(PLL_LOCK_CYCLES)),
		.done(pll_done)
	);

	always_comb begin
		next_state = state;
		case (state)
			BS_ST_HOLD: begin
				if (power_up_timer_enabled) begin
					next_state = BS_ST_POWER_UP_TIMER;
				end else if (use_ost) begin
					next_state = BS_ST_OST;
				end else begin
					next_state = BS_ST_DONE;
				end
			end
			BS_ST_POWER_UP_TIMER: begin
				if (power_up_timer_done) begin
					next_state = use_ost ? BS_ST_OST : BS_ST_DONE;
				end
			end
			BS_ST_OST: begin
				if (ost_done) begin
					next_state = use_pll ? BS_ST_PLL : BS_ST_DONE;
				end
			end
			BS_ST_PLL: begin
				if (pll_done) begin
					next_state = BS_ST_DONE;
				end
			end
			BS_ST_DONE: begin
				if (osc_restart && use_ost) begin
					next_state = BS_ST_OST;
				end
			end
			default: next_state = BS_ST_HOLD;
		endcase
		if (por_level || brownout_reset) begin
			next_state = BS_ST_HOLD;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state <= BS_ST_HOLD;
		end else begin
			state <= next_state;
		end
	end

	// A restart after wake only stalls the clock; a reset source replays the chain.
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			in_reset_chain <= 1'b1;
		end else if (next_state == BS_ST_HOLD) begin
			in_reset_chain <= 1'b1;
		end else if (next_state == BS_ST_DONE) begin
			in_reset_chain <= 1'b0;
		end
	end

	// The timers never look at master clear, so a late pin release runs at once.
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			core_reset_n <= 1'b0;
			osc_ready <= 1'b0;
		end else begin
			core_reset_n <= ((next_state == BS_ST_DONE) || !in_reset_chain)
				&& (next_state != BS_ST_HOLD) && master_clear_pin_n_level && !por_level
				&& !brownout_reset;
			osc_ready <= (next_state == BS_ST_DONE);
		end
	end

	// ------------------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------------------
	logic [31:0] next_rdata;

	always_comb begin
		next_rdata = 32'h0000_0000;
		case (reg_select(paddr))
			BS_REG_CTRL: next_rdata[`BS_CTRL_SWEN_BIT] = software_brownout_enable;
			BS_REG_STATUS: begin
				next_rdata[`BS_STAT_SETTLED_BIT] = settled_level;
				next_rdata[`BS_STAT_BOR_ACTIVE_BIT] = brownout_active;
				next_rdata[`BS_STAT_CORE_RUN_BIT] = core_reset_n;
				next_rdata[`BS_STAT_OSC_READY_BIT] = osc_ready;
				next_rdata[`BS_STAT_STATE_MSB:`BS_STAT_STATE_LSB] = state;
				next_rdata[`BS_STAT_BOR_FLAG_BIT] = bor_flag;
			end
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// Read data is captured in the setup cycle, so every access ends in one wait-free phase.
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			prdata <= pwrite ? 32'h0000_0000 : next_rdata;
			pslverr <= (reg_select(paddr) == BS_REG_NONE);
		end
	end

	assign pready = psel && penable;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	property p_cfg_off;
		@(posedge sys_clk) disable iff (!resetn)
		brownout_enable_config == BS_BOR_OFF |=> !brownout_active;
	endproperty
	a_cfg_off: assert property (p_cfg_off) else $error("Detection on with config off.");

	property p_cfg_on;
		@(posedge sys_clk) disable iff (!resetn)
		brownout_enable_config == BS_BOR_ALWAYS_ON |=> brownout_active;
	endproperty
	a_cfg_on: assert property (p_cfg_on) else $error("Detection off with config on.");

	property p_sleep_off;
		@(posedge sys_clk) disable iff (!resetn)
		(brownout_enable_config == BS_BOR_SLEEP_GATED) && sleep_mode |=> !brownout_active;
	endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("Detection on in sleep.");

	property p_wake_on;
		@(posedge sys_clk) disable iff (!resetn)
		(brownout_enable_config == BS_BOR_SLEEP_GATED) && !sleep_mode |=> brownout_active;
	endproperty
	a_wake_on: assert property (p_wake_on) else $error("Detection off when awake.");

	property p_sw_follow;
		@(posedge sys_clk) disable iff (!resetn)
		$stable(brownout_enable_config) && (brownout_enable_config == BS_BOR_SOFTWARE)
			|=> brownout_active == $past(software_brownout_enable);
	endproperty
	a_sw_follow: assert property (p_sw_follow) else $error("Detection ignores enable bit.");

	property p_ref_req;
		@(posedge sys_clk) disable iff (!resetn)
		brownout_active |-> fixed_voltage_reference_request;
	endproperty
	a_ref_req: assert property (p_ref_req) else $error("Reference not requested.");

	property p_trip_cause;
		@(posedge sys_clk) disable iff (!resetn)
		$rose(brownout_reset) |-> $past(brownout_active) && $past(settled_level);
	endproperty
	a_trip_cause: assert property (p_trip_cause) else $error("Trip without settled enable.");

	property p_swen_zero;
		@(posedge sys_clk) disable iff (!resetn)
		(brownout_enable_config != BS_BOR_SOFTWARE) |=> !software_brownout_enable;
	endproperty
	a_swen_zero: assert property (p_swen_zero) else $error("Enable bit reads set.");

	property p_power_up_timer_gate;
		@(posedge sys_clk) disable iff (!resetn)
		state == BS_ST_POWER_UP_TIMER |-> !core_reset_n && $past(!power_up_timer_disable_n);
	endproperty
	a_power_up_timer_gate: assert property (p_power_up_timer_gate) else $error("Power-up timer misgated.");

	property p_ost_mode;
		@(posedge sys_clk) disable iff (!resetn)
		$rose(state == BS_ST_OST) |-> $past(use_ost);
	endproperty
	a_ost_mode: assert property (p_ost_mode) else $error("Start-up count in wrong mode.");

	property p_bor_restart;
		@(posedge sys_clk) disable iff (!resetn)
		brownout_reset |=> state == BS_ST_HOLD ##1 !core_reset_n;
	endproperty
	a_bor_restart: assert property (p_bor_restart) else $error("Brown-out did not restart.");

	property p_core_release;
		@(posedge sys_clk) disable iff (!resetn)
		core_reset_n |-> state != BS_ST_HOLD && state != BS_ST_POWER_UP_TIMER && !in_reset_chain
			&& $past(master_clear_pin_n_level);
	endproperty
	a_core_release: assert property (p_core_release) else $error("Core released early.");
endmodule

// ==== core/bs_regs.svh ====
// Register offsets, field positions and timing constants of the start-up sequencer.
`ifndef BS_REGS_SVH
`define BS_REGS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define BS_ADDR_W 12
`define BS_OFF_CTRL 12'h000
`define BS_OFF_STATUS 12'h004
`define BS_CTRL_SWEN_BIT 0
`define BS_STAT_SETTLED_BIT 0
`define BS_STAT_BOR_ACTIVE_BIT 1
`define BS_STAT_CORE_RUN_BIT 2
`define BS_STAT_OSC_READY_BIT 3
`define BS_STAT_STATE_LSB 4
`define BS_STAT_STATE_MSB 6
`define BS_STAT_BOR_FLAG_BIT 8

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define BS_POWER_UP_TIMER_W 12
`define BS_POWER_UP_TIMER_TICKS 12'h800
`define BS_OST_W 11
`define BS_OST_TICKS 11'h400
`define BS_CLK_PERIOD_PS 5000
`define BS_PLL_LOCK_PS 2000000000
`define BS_PLL_CNT_W 19

// ----------------------------------------------------------------------------
// Asynchronous input slots
// ----------------------------------------------------------------------------
`define BS_NUM_ASYNC 6
`define BS_IN_POR 0
`define BS_IN_BOR_CMP 1
`define BS_IN_MASTER_CLEAR_PIN_N_N 2
`define BS_IN_LFOSC 3
`define BS_IN_POSC 4
`define BS_IN_SETTLED 5

`endif

// ==== core/bs_pkg.sv ====
// Types shared by the start-up sequencer modules.
package bs_pkg;

	typedef enum logic [1:0] {
		BS_BOR_OFF = 2'b00,
		BS_BOR_SOFTWARE = 2'b01,
		BS_BOR_SLEEP_GATED = 2'b10,
		BS_BOR_ALWAYS_ON = 2'b11
	} bs_bor_cfg_t;

	typedef enum logic [2:0] {
		BS_OSC_LOW_POWER_CRYSTAL = 3'b000,
		BS_OSC_CRYSTAL = 3'b001,
		BS_OSC_HIGH_SPEED_CRYSTAL = 3'b010,
		BS_OSC_HIGH_SPEED_PLL = 3'b011,
		BS_OSC_EXTERNAL_CLOCK = 3'b100,
		BS_OSC_RESISTOR_CAPACITOR = 3'b101,
		BS_OSC_INTERNAL = 3'b110
	} bs_osc_mode_t;

	typedef enum logic [2:0] {
		BS_ST_HOLD = 3'b000,
		BS_ST_POWER_UP_TIMER = 3'b001,
		BS_ST_OST = 3'b010,
		BS_ST_PLL = 3'b011,
		BS_ST_DONE = 3'b100
	} bs_state_t;

endpackage

// ==== core/bs_sync.sv ====
// Three-flop synchroniser with agreement filter and rising-edge pulse.
`timescale 1ns/1ps
module bs_sync (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic async_in,
	output logic level,
	output logic rise
);
	logic meta;
	logic stage2;
	logic stage3;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			meta <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
		end else begin
			meta <= async_in;
			stage2 <= meta;
			stage3 <= stage2;
		end
	end

	// The level moves only when the second and third stages agree.
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			level <= 1'b0;
			rise <= 1'b0;
		end else begin
			if (stage2 == stage3) begin
				level <= stage3;
			end
			rise <= (stage2 == stage3) && stage3 && !level;
		end
	end
endmodule

// ==== core/bs_tick_counter.sv ====
// Tick counter that raises done once a target count of ticks is reached.
`timescale 1ns/1ps
module bs_tick_counter #(
	parameter int WIDTH = 12
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic run,
	input wire logic tick,
	input wire logic [WIDTH-1:0] target,
	output logic done
);
	logic [WIDTH-1:0] count;

	// Dropping run reinitialises the count, so an interrupted stage restarts.
	always_ff @(posedge sys_clk) begin
		if (!resetn || !run) begin
			count <= '0;
		end else if (tick && (count != target)) begin
			count <= count + 1'b1;
		end
	end

	assign done = run && (count == target);
endmodule

// ==== test/bs_partner.sv ====
// Model of the reset sources, oscillators and voltage reference around the sequencer.
`timescale 1ns/1ps
module bs_partner #(
	parameter int SETTLE = 40
) (
	input wire logic sys_clk,
	input wire logic por_cmd,
	input wire logic low_cmd,
	input wire logic master_clear_pin_n_cmd,
	input wire logic fixed_voltage_reference_request,
	output logic power_on_pulse,
	output logic brownout_comparator,
	output logic master_clear_pin_n,
	output logic low_freq_internal_osc,
	output logic primary_osc_input,
	output logic reference_settled
);
	int settle_cnt = 0;

	// ------------------------------------------------------------------------
	// Oscillators
	// ------------------------------------------------------------------------
	// Both run free and out of phase with sys_clk, as real oscillators would.
	initial begin
		low_freq_internal_osc = 1'h0;
		primary_osc_input = 1'h0;
	end
	always #25 low_freq_internal_osc = ~low_freq_internal_osc;
	always #24 primary_osc_input = ~primary_osc_input;

	// ------------------------------------------------------------------------
	// Reference and reset sources
	// ------------------------------------------------------------------------
	// The reference loses its settled state at once when the request drops, so a
	// short enable period never reaches the settled level.
	always_ff @(posedge sys_clk) begin
		if (!fixed_voltage_reference_request) begin
			settle_cnt <= 0;
		end else if (settle_cnt < SETTLE) begin
			settle_cnt <= settle_cnt + 1;
		end
	end
	assign reference_settled = (settle_cnt == SETTLE);
	assign power_on_pulse = por_cmd;
	assign brownout_comparator = low_cmd;
	assign master_clear_pin_n = master_clear_pin_n_cmd;
endmodule

// ==== test/bs_seq_tb_top.sv ====
// Self-checking bench for the brown-out and start-up sequencer.
`timescale 1ns/1ps
`include "bs_regs.svh"
module bs_seq_tb_top import bs_pkg::*; ;
	logic sys_clk = 1'h0;
	logic resetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [1:0] cfg = 2'h2;
	logic pdn = 1'h0;
	logic [2:0] mode = BS_OSC_HIGH_SPEED_PLL;
	logic sleep_mode = 1'h0;
	logic osc_restart = 1'h0;
	logic por_cmd = 1'h1;
	logic low_cmd = 1'h0;
	logic master_clear_pin_n_cmd = 1'h0;
	logic [31:0] prdata;
	logic pready, pslverr, por, bcmp, master_clear_pin_n_n, lfosc, posc, settled;
	logic brownout_active, fvr_req, brownout_reset, osc_ready, core_reset_n;
	logic [31:0] rdata;
	logic rerr;
	int error_cnt = 0;
	int check_count = 0;
	int n;

	always #2.5 sys_clk = ~sys_clk;

	bs_seq #(.PLL_LOCK_CYCLES(20)) dut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .power_on_pulse(por), .brownout_comparator(bcmp),
		.master_clear_pin_n(master_clear_pin_n_n), .low_freq_internal_osc(lfosc), .primary_osc_input(posc),
		.reference_settled(settled), .brownout_enable_config(cfg),
		.power_up_timer_disable_n(pdn), .osc_mode(mode), .sleep_mode(sleep_mode),
		.osc_restart(osc_restart), .brownout_active(brownout_active),
		.fixed_voltage_reference_request(fvr_req), .brownout_reset(brownout_reset),
		.osc_ready(osc_ready), .core_reset_n(core_reset_n));

	bs_partner partner (.sys_clk(sys_clk), .por_cmd(por_cmd), .low_cmd(low_cmd),
		.master_clear_pin_n_cmd(master_clear_pin_n_cmd), .fixed_voltage_reference_request(fvr_req),
		.power_on_pulse(por), .brownout_comparator(bcmp), .master_clear_pin_n(master_clear_pin_n_n),
		.low_freq_internal_osc(lfosc), .primary_osc_input(posc), .reference_settled(settled));

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] win(input int v, input int lo, input int hi);
		return 32'(v >= lo && v <= hi);
	endfunction

	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk);
	endtask

	// Counts edges into n; a wait that runs out is a mismatch and ends the run.
	task automatic wait_lvl(ref logic s, input logic v, input int lim);
		n = 0;
		while (s !== v && n < lim) begin
			@(posedge sys_clk);
			n++;
		end
		check(32'(s), 32'(v));
		if (s !== v) finish_test();
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'h1 && k < 20);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		check(32'(pready), 32'h1);
		if (pready !== 1'h1) finish_test();
		@(posedge sys_clk);
	endtask

	task automatic restart(input logic [1:0] c, input logic d, input logic [2:0] m);
		resetn <= 1'h0;
		cfg <= c;
		pdn <= d;
		mode <= m;
		cyc(4);
		resetn <= 1'h1;
	endtask

	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	// Window bounds allow for oscillator phase and synchroniser delay.
	task automatic power_up();
		cyc(2);
		check(32'(core_reset_n), 32'h0);
		por_cmd <= 1'h0;
		wait_lvl(osc_ready, 1'h1, 40000);
		check(win(n, 30250, 30500), 32'h1);
		apb(1'h0, `BS_OFF_STATUS, 32'h0);
		check(rdata & 32'h17F, 32'h04B);
		check(32'(core_reset_n), 32'h0);
		master_clear_pin_n_cmd <= 1'h1;
		wait_lvl(core_reset_n, 1'h1, 8);
	endtask

	task automatic sleep_gate();
		check(32'({brownout_active, fvr_req}), 32'h3);
		sleep_mode <= 1'h1;
		cyc(3);
		check(32'({brownout_active, fvr_req}), 32'h0);
		sleep_mode <= 1'h0;
		cyc(3);
		check(32'({brownout_active, fvr_req}), 32'h3);
		low_cmd <= 1'h1;
		cyc(20);
		apb(1'h0, `BS_OFF_STATUS, 32'h0);
		check(32'({brownout_reset, rdata[0]}), 32'h0);
		sleep_mode <= 1'h1;
		cyc(60);
		check(32'({brownout_reset, core_reset_n}), 32'h1);
		sleep_mode <= 1'h0;
		wait_lvl(brownout_reset, 1'h1, 80);
		wait_lvl(core_reset_n, 1'h0, 4);
		apb(1'h0, `BS_OFF_STATUS, 32'h0);
		check(rdata & 32'h17F, 32'h103);
	endtask

	task automatic bor_restart();
		low_cmd <= 1'h0;
		cyc(5000);
		check(32'(core_reset_n), 32'h0);
		low_cmd <= 1'h1;
		wait_lvl(brownout_reset, 1'h1, 20);
		low_cmd <= 1'h0;
		wait_lvl(core_reset_n, 1'h1, 40000);
		check(win(n, 30250, 30500), 32'h1);
		apb(1'h1, `BS_OFF_STATUS, 32'h100);
		apb(1'h0, `BS_OFF_STATUS, 32'h0);
		check(rdata & 32'h100, 32'h0);
	endtask

	task automatic configs();
		logic [1:0] c;
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			restart(c, 1'h1, BS_OSC_RESISTOR_CAPACITOR);
			wait_lvl(core_reset_n, 1'h1, 12);
			check(32'(brownout_active), 32'(c != 2'h0));
			apb(1'h0, `BS_OFF_CTRL, 32'h0);
			check(rdata, 32'(c == 2'h1));
			apb(1'h1, `BS_OFF_CTRL, 32'h0);
			cyc(1);
			check(32'(brownout_active), 32'(c[1]));
			apb(1'h1, `BS_OFF_CTRL, 32'h1);
			apb(1'h0, `BS_OFF_CTRL, 32'h0);
			check(rdata, 32'(c == 2'h1));
			check(32'(brownout_active), 32'(c != 2'h0));
		end
		apb(1'h0, 12'h008, 32'h0);
		check(32'({rerr, rdata == 32'h0}), 32'h3);
	endtask

	task automatic osc_restart_test();
		restart(2'h0, 1'h1, BS_OSC_CRYSTAL);
		wait_lvl(osc_ready, 1'h1, 12000);
		check(win(n, 9750, 10000), 32'h1);
		osc_restart <= 1'h1;
		cyc(1);
		osc_restart <= 1'h0;
		cyc(3);
		check(32'({osc_ready, core_reset_n}), 32'h1);
		wait_lvl(osc_ready, 1'h1, 12000);
		check(win(n, 9750, 10000), 32'h1);
		restart(2'h0, 1'h1, BS_OSC_RESISTOR_CAPACITOR);
		wait_lvl(osc_ready, 1'h1, 12);
		osc_restart <= 1'h1;
		cyc(1);
		osc_restart <= 1'h0;
		cyc(3);
		check(32'(osc_ready), 32'h1);
	endtask

	initial begin
		cyc(3);
		resetn <= 1'h1;
		power_up();
		sleep_gate();
		bor_restart();
		configs();
		osc_restart_test();
		finish_test();
	end
endmodule
